// ### shared/pss_pkg.sv
// Package for the status summary register block: offsets, bit positions,
// reset values and the packed carriers shared by the design files.
// Assumes a 16-bit management register space addressed by 5-bit offsets.
package pss_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_BASIC_MODE_STATUS = 5'h01;
    localparam logic [4:0] OFS_AUTONEG_EXPANSION = 5'h06;
    localparam logic [4:0] OFS_PHY_STATUS_SUMMARY = 5'h10;
    localparam logic [4:0] OFS_INTERRUPT_STATUS_EVENT = 5'h12;
    localparam logic [4:0] OFS_FALSE_CARRIER_COUNTER = 5'h14;
    localparam logic [4:0] OFS_RX_ERROR_COUNT = 5'h15;
    localparam logic [4:0] OFS_PCS_CONFIG = 5'h16;
    localparam logic [4:0] OFS_PHY_CONTROL = 5'h19;
    localparam logic [4:0] OFS_TENBASE_STATUS_CONTROL = 5'h1a;

    // ------------------------------------------------------------------
    // Summary register bit positions
    // ------------------------------------------------------------------
    localparam int unsigned BIT_RESERVED = 15;
    localparam int unsigned BIT_CROSSOVER_MODE = 14;
    localparam int unsigned BIT_RX_ERROR_LATCH = 13;
    localparam int unsigned BIT_POLARITY = 12;
    localparam int unsigned BIT_FALSE_CARRIER = 11;
    localparam int unsigned BIT_SIGNAL_DETECT = 10;
    localparam int unsigned BIT_DESCR_LOCK = 9;
    localparam int unsigned BIT_PAGE_RECEIVED = 8;
    localparam int unsigned BIT_INT_PENDING = 7;
    localparam int unsigned BIT_REMOTE_FAULT = 6;

    // Control bit positions
    localparam int unsigned BIT_QUALIFY_SD = 8;
    localparam int unsigned BIT_XOVER_AUTO_EN = 15;
    localparam int unsigned BIT_XOVER_FORCE = 14;
    localparam int unsigned BIT_TENBASE_POLARITY = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_QUALIFY_SD = 1'b1;
    localparam logic RST_XOVER_AUTO_EN = 1'b1;
    localparam logic RST_XOVER_FORCE = 1'b0;
    localparam logic [15:0] RST_RDATA = 16'h0000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // One-cycle event pulses from the neighbouring blocks
    typedef struct packed {
        logic rx_error;
        logic false_carrier;
        logic polarity_inverted;
        logic page_received;
        logic interrupt;
        logic remote_fault;
    } pss_events_t;

    // Management port request
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pss_req_t;

    // Whole state of the summary block
    typedef struct packed {
        logic rx_error;
        logic false_carrier;
        logic polarity;
        logic sd_low_latch;
        logic lock_low_latch;
        logic page_received;
        logic int_pending;
        logic remote_fault;
        logic crossover_mode;
        logic qualify_sd;
        logic xover_auto_en;
        logic xover_force;
        logic [15:0] rdata;
    } pss_state_t;

endpackage

// ### verilog/pss_sync.sv
// Two-stage level synchroniser for a bus of independent bits.
// Assumes each bit is a slow level; no bit-to-bit coherence is promised.
`timescale 1ns/10ps

module pss_sync #(
    parameter int unsigned WIDTH = 2
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (WIDTH < 1)
    begin : g_bad_width
        $error("pss_sync needs at least one bit");
    end

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    // First stage feeds only the second stage
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic meta_r;
        logic sync_r;
        always_ff @(posedge mclk or negedge nrst)
        begin
            if (!nrst)
            begin
                meta_r <= 1'b0;
                sync_r <= 1'b0;
            end
            else
            begin
                meta_r <= async_in[i];
                sync_r <= meta_r;
            end
        end
        assign sync_out[i] = sync_r;
    end

endmodule

// ### verilog/pss_summary.sv
// Summary status register block: upper ten bits of the PHY status summary,
// its two steering control registers, and the clearing reads it snoops.
// Assumes it sees every read of the management port, so clearing reads of
// source registers held elsewhere are observed here by address.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps

module pss_summary #(
    parameter int unsigned DATA_W = pss_pkg::DATA_W,
    parameter int unsigned ADDR_W = pss_pkg::ADDR_W
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire pss_pkg::pss_events_t events,
    input wire logic crossover_swap,
    input wire logic signal_detect_raw,
    input wire logic descrambler_lock_raw,
    output logic crossover_mode,
    output logic signal_detect_qualified
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (DATA_W != pss_pkg::DATA_W)
    begin : g_bad_data_w
        $error("pss_summary supports a 16-bit register width only");
    end

    if (ADDR_W != pss_pkg::ADDR_W)
    begin : g_bad_addr_w
        $error("pss_summary supports a 5-bit register address only");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pss_pkg::pss_state_t state_r;
    pss_pkg::pss_state_t state_nxt;
    pss_pkg::pss_req_t req;
    logic [1:0] pmd_async;
    logic [1:0] pmd_sync;
    logic sd_raw_s;
    logic lock_s;
    logic sd_current;
    logic rd_summary;
    logic rd_basic_status;
    logic rd_expansion;
    logic rd_int_status;
    logic rd_false_carrier;
    logic rd_rx_error;
    logic rd_tenbase;
    logic wr_pcs_config;
    logic wr_phy_control;
    logic [15:0] summary_word;
    logic [15:0] pcs_config_word;
    logic [15:0] phy_control_word;

    // ------------------------------------------------------------------
    // Request bundle
    // ------------------------------------------------------------------
    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    // ------------------------------------------------------------------
    // Receiver status from the PMD
    // ------------------------------------------------------------------
    // These come from the recovered receive clock, so they are resynced
    assign pmd_async[0] = signal_detect_raw;
    assign pmd_async[1] = descrambler_lock_raw;

    pss_sync #(
        .WIDTH(2)
    ) u_pmd_sync (
        .mclk(mclk),
        .nrst(nrst),
        .async_in(pmd_async),
        .sync_out(pmd_sync)
    );

    assign sd_raw_s = pmd_sync[0];
    assign lock_s = pmd_sync[1];

    // Qualified detect, as fed to the link monitor
    always_comb
    begin
        if (state_r.qualify_sd)
        begin
            sd_current = sd_raw_s & lock_s;
        end
        else
        begin
            sd_current = sd_raw_s;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Reads of neighbouring registers are snooped for their clear effect
    assign rd_summary = req.rd && (req.addr == pss_pkg::OFS_PHY_STATUS_SUMMARY);
    assign rd_basic_status = req.rd && (req.addr == pss_pkg::OFS_BASIC_MODE_STATUS);
    assign rd_expansion = req.rd && (req.addr == pss_pkg::OFS_AUTONEG_EXPANSION);
    assign rd_int_status = req.rd && (req.addr == pss_pkg::OFS_INTERRUPT_STATUS_EVENT);
    assign rd_false_carrier = req.rd && (req.addr == pss_pkg::OFS_FALSE_CARRIER_COUNTER);
    assign rd_rx_error = req.rd && (req.addr == pss_pkg::OFS_RX_ERROR_COUNT);
    assign rd_tenbase = req.rd && (req.addr == pss_pkg::OFS_TENBASE_STATUS_CONTROL);
    assign wr_pcs_config = req.wr && (req.addr == pss_pkg::OFS_PCS_CONFIG);
    assign wr_phy_control = req.wr && (req.addr == pss_pkg::OFS_PHY_CONTROL);

    // ------------------------------------------------------------------
    // Read words
    // ------------------------------------------------------------------
    always_comb
    begin
        summary_word = '0;
        summary_word[pss_pkg::BIT_RESERVED] = 1'b0;
        summary_word[pss_pkg::BIT_CROSSOVER_MODE] = state_r.crossover_mode;
        summary_word[pss_pkg::BIT_RX_ERROR_LATCH] = state_r.rx_error;
        summary_word[pss_pkg::BIT_POLARITY] = state_r.polarity;
        summary_word[pss_pkg::BIT_FALSE_CARRIER] = state_r.false_carrier;
        summary_word[pss_pkg::BIT_SIGNAL_DETECT] = state_r.sd_low_latch;
        summary_word[pss_pkg::BIT_DESCR_LOCK] = state_r.lock_low_latch;
        summary_word[pss_pkg::BIT_PAGE_RECEIVED] = state_r.page_received;
        summary_word[pss_pkg::BIT_INT_PENDING] = state_r.int_pending;
        summary_word[pss_pkg::BIT_REMOTE_FAULT] = state_r.remote_fault;
    end

    always_comb
    begin
        pcs_config_word = '0;
        pcs_config_word[pss_pkg::BIT_QUALIFY_SD] = state_r.qualify_sd;
    end

    always_comb
    begin
        phy_control_word = '0;
        phy_control_word[pss_pkg::BIT_XOVER_AUTO_EN] = state_r.xover_auto_en;
        phy_control_word[pss_pkg::BIT_XOVER_FORCE] = state_r.xover_force;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;

        // Control registers; the summary itself is read-only
        if (wr_pcs_config)
        begin
            state_nxt.qualify_sd = req.wdata[pss_pkg::BIT_QUALIFY_SD];
        end
        if (wr_phy_control)
        begin
            state_nxt.xover_auto_en = req.wdata[pss_pkg::BIT_XOVER_AUTO_EN];
            state_nxt.xover_force = req.wdata[pss_pkg::BIT_XOVER_FORCE];
        end

        // Crossover: force wins over the algorithm
        if (state_r.xover_force)
        begin
            state_nxt.crossover_mode = 1'b1;
        end
        else if (state_r.xover_auto_en)
        begin
            state_nxt.crossover_mode = crossover_swap;
        end
        else
        begin
            state_nxt.crossover_mode = 1'b0;
        end

        // Latch-high flags: an event in the clearing cycle wins
        state_nxt.rx_error = (state_r.rx_error & ~rd_rx_error)
            | events.rx_error;
        state_nxt.false_carrier = (state_r.false_carrier & ~rd_false_carrier)
            | events.false_carrier;
        state_nxt.polarity = (state_r.polarity & ~rd_tenbase)
            | events.polarity_inverted;
        state_nxt.page_received = (state_r.page_received & ~rd_expansion)
            | events.page_received;
        state_nxt.int_pending = (state_r.int_pending & ~rd_int_status)
            | events.interrupt;
        state_nxt.remote_fault = (state_r.remote_fault & ~rd_basic_status)
            | events.remote_fault;

        // Latch-low flags: a read shows the held value, then resamples
        if (rd_summary)
        begin
            state_nxt.sd_low_latch = sd_current;
            state_nxt.lock_low_latch = lock_s;
        end
        else
        begin
            state_nxt.sd_low_latch = state_r.sd_low_latch & sd_current;
            state_nxt.lock_low_latch = state_r.lock_low_latch & lock_s;
        end

        // Read data stands for exactly the cycle after the strobe
        state_nxt.rdata = pss_pkg::RST_RDATA;
        if (req.rd)
        begin
            case (req.addr)
                pss_pkg::OFS_PHY_STATUS_SUMMARY:
                begin
                    state_nxt.rdata = summary_word;
                end
                pss_pkg::OFS_PCS_CONFIG:
                begin
                    state_nxt.rdata = pcs_config_word;
                end
                pss_pkg::OFS_PHY_CONTROL:
                begin
                    state_nxt.rdata = phy_control_word;
                end
                default:
                begin
                    // Unmapped here: answers zero
                    state_nxt.rdata = pss_pkg::RST_RDATA;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r.rx_error <= 1'b0;
            state_r.false_carrier <= 1'b0;
            state_r.polarity <= 1'b0;
            state_r.sd_low_latch <= 1'b0;
            state_r.lock_low_latch <= 1'b0;
            state_r.page_received <= 1'b0;
            state_r.int_pending <= 1'b0;
            state_r.remote_fault <= 1'b0;
            state_r.crossover_mode <= 1'b0;
            state_r.qualify_sd <= pss_pkg::RST_QUALIFY_SD;
            state_r.xover_auto_en <= pss_pkg::RST_XOVER_AUTO_EN;
            state_r.xover_force <= pss_pkg::RST_XOVER_FORCE;
            state_r.rdata <= pss_pkg::RST_RDATA;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = state_r.rdata;
    assign crossover_mode = state_r.crossover_mode;
    assign signal_detect_qualified = state_r.sd_low_latch;

endmodule

// ### verification/pss_summary_monitor.sv
// Concurrent checks on the summary block, seen from its ports only.
// Assumes one clock, mclk, and nrst as asynchronous active-low reset.
`timescale 1ns/10ps

module pss_summary_monitor #(
    parameter int unsigned DATA_W = pss_pkg::DATA_W,
    parameter int unsigned ADDR_W = pss_pkg::ADDR_W
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire pss_pkg::pss_events_t events,
    input wire logic crossover_swap,
    input wire logic signal_detect_raw,
    input wire logic descrambler_lock_raw,
    input wire logic crossover_mode,
    input wire logic signal_detect_qualified
);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence s_sum_rd;
        reg_rd && reg_addr == pss_pkg::OFS_PHY_STATUS_SUMMARY;
    endsequence

    // Clearing read with no new event in the same cycle
    sequence s_src_rd(ofs, ev);
        reg_rd && reg_addr == ofs && !ev;
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_top_bit_zero: assert property (
        reg_wr && reg_wdata[15] ##1 s_sum_rd |=> !reg_rdata[15])
        else $error("top summary bit not zero");
    a_xover_seen: assert property (
        s_sum_rd |=> reg_rdata[14] == $past(crossover_mode))
        else $error("crossover bit differs from crossover output");
    // Write to control moves the output two edges later; the check allows up to three
    a_xover_cause: assert property (
        $changed(crossover_mode) |-> crossover_mode == $past(crossover_swap)
        || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("crossover output moved without cause");
    a_rx_err_set: assert property (
        events.rx_error ##1 s_sum_rd |=> reg_rdata[13])
        else $error("receive error latch not set");
    a_pol_keep: assert property (
        s_sum_rd ##1 (s_sum_rd and reg_rdata[12]) |=> reg_rdata[12])
        else $error("polarity cleared by summary read");
    a_fc_clear: assert property (
        s_src_rd(pss_pkg::OFS_FALSE_CARRIER_COUNTER, events.false_carrier)
        ##1 s_sum_rd |=> !reg_rdata[11])
        else $error("false carrier latch not cleared");
    a_sd_low: assert property (
        (!signal_detect_raw) [*5] ##1 s_sum_rd |=> !reg_rdata[10])
        else $error("signal detect not low after raw drop");
    a_lock_low: assert property (
        (!descrambler_lock_raw) [*5] ##1 s_sum_rd |=> !reg_rdata[9])
        else $error("lock bit not low after lock loss");
    a_page_keep: assert property (
        s_sum_rd ##1 (s_sum_rd and reg_rdata[8]) |=> reg_rdata[8])
        else $error("page received cleared by summary read");
    a_int_clear: assert property (
        s_src_rd(pss_pkg::OFS_INTERRUPT_STATUS_EVENT, events.interrupt)
        ##1 s_sum_rd |=> !reg_rdata[7])
        else $error("interrupt pending not cleared");
    a_rf_clear: assert property (
        s_src_rd(pss_pkg::OFS_BASIC_MODE_STATUS, events.remote_fault)
        ##1 s_sum_rd |=> !reg_rdata[6])
        else $error("remote fault not cleared");
    a_sd_mirror: assert property (
        s_sum_rd |=> reg_rdata[10] == $past(signal_detect_qualified))
        else $error("signal detect bit differs from its output");
endmodule

bind pss_summary pss_summary_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_pss_summary_monitor (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events),
    .crossover_swap(crossover_swap), .signal_detect_raw(signal_detect_raw),
    .descrambler_lock_raw(descrambler_lock_raw), .crossover_mode(crossover_mode),
    .signal_detect_qualified(signal_detect_qualified));

// ### verification/pss_summary_tb.sv
// Bench for the summary block: drives port, events and PMD levels and
// predicts every read answer with a small model.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps

module pss_summary_tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    pss_pkg::pss_events_t events = '0;
    logic crossover_swap = 1'b0;
    logic signal_detect_raw = 1'b1;
    logic descrambler_lock_raw = 1'b1;
    logic crossover_mode;
    logic signal_detect_qualified;
    int n_errors = 0;
    int check_count = 0;
    int seed = 95;
    logic [15:0] m_lh;
    logic [15:0] pend = 16'h0000;
    logic m_sd, m_lk, m_qual, m_auto, m_force;
    // Clearing offsets in event order, then summary and an unmapped one
    logic [4:0] ofs [8] = '{5'h15, 5'h14, 5'h1a, 5'h06, 5'h12, 5'h01, 5'h10, 5'h03};

    pss_summary i_pss_summary (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .events(events), .crossover_swap(crossover_swap), .signal_detect_raw(signal_detect_raw),
        .descrambler_lock_raw(descrambler_lock_raw), .crossover_mode(crossover_mode),
        .signal_detect_qualified(signal_detect_qualified));

    always #20 mclk = ~mclk;

    // ------------------------------------------------------------------
    // Model
    // ------------------------------------------------------------------
    function automatic logic [15:0] ev_bits(input logic [5:0] e);
        ev_bits = {2'b00, e[5], e[3], e[4], 2'b00, e[2], e[1], e[0], 6'h00};
    endfunction

    function automatic logic [15:0] clr_bits(input logic [4:0] a);
        case (a)
            5'h15: clr_bits = 16'h2000;
            5'h14: clr_bits = 16'h0800;
            5'h1a: clr_bits = 16'h1000;
            5'h06: clr_bits = 16'h0100;
            5'h12: clr_bits = 16'h0080;
            5'h01: clr_bits = 16'h0040;
            default: clr_bits = 16'h0000;
        endcase
    endfunction

    function automatic logic xo_exp();
        xo_exp = m_force | (m_auto & crossover_swap);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    // Entered at a rising edge; the answer of the previous request is
    // checked at the falling edge so back-to-back strobes stay legal.
    task automatic step(input logic [4:0] a, input logic w, input logic r,
        input logic [15:0] d, input logic [5:0] e);
        reg_addr <= a;
        reg_wr <= w;
        reg_rd <= r;
        reg_wdata <= d;
        events <= e;
        @(negedge mclk);
        check(reg_rdata, pend);
        pend = 16'h0000;
        if (r && a == 5'h10)
            pend = m_lh | {1'b0, xo_exp(), 3'b000, m_sd, m_lk, 9'h000};
        if (r && a == 5'h16)
            pend = {7'h00, m_qual, 8'h00};
        if (r && a == 5'h19)
            pend = {m_auto, m_force, 14'h0000};
        if (r)
            m_lh = m_lh & ~clr_bits(a);
        m_lh = m_lh | ev_bits(e);
        if (r && a == 5'h10)
        begin
            m_lk = descrambler_lock_raw;
            m_sd = signal_detect_raw & (descrambler_lock_raw | ~m_qual);
        end
        if (w && a == 5'h16)
            m_qual = d[8];
        if (w && a == 5'h19)
            {m_auto, m_force} = d[15:14];
        @(posedge mclk);
    endtask

    task automatic idle(input int n);
        repeat (n) step(5'h00, 1'b0, 1'b0, 16'h0000, 6'h00);
    endtask

    task automatic rd(input logic [4:0] a);
        step(a, 1'b0, 1'b1, 16'h0000, 6'h00);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        step(a, 1'b1, 1'b0, d, 6'h00);
    endtask

    task automatic pins(input logic sd, input logic lk);
        signal_detect_raw <= sd;
        descrambler_lock_raw <= lk;
        if (!lk)
            m_lk = 1'b0;
        if (!sd || (!lk && m_qual))
            m_sd = 1'b0;
        idle(5);
        check({15'h0000, signal_detect_qualified}, {15'h0000, m_sd});
    endtask

    // Drop, read while low, restore, then two reads to see release
    task automatic low_pulse(input logic sd, input logic lk);
        pins(sd, lk);
        rd(5'h10);
        pins(1'b1, 1'b1);
        rd(5'h10);
        rd(5'h10);
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        events <= '0;
        {m_lh, pend} = 32'h0000_0000;
        {m_sd, m_lk, m_qual, m_auto, m_force} = 5'b00110;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        idle(2);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [31:0] r;
        do_reset();
        rd(5'h10);
        rd(5'h10);
        wr(5'h10, 16'hffff);
        rd(5'h10);
        rd(5'h03);
        for (int i = 0; i < 8; i++)
        begin
            crossover_swap <= i[0];
            wr(5'h19, {i[2:1], 14'h0000});
            rd(5'h19);
            idle(3);
            rd(5'h10);
            check({15'h0000, crossover_mode}, {15'h0000, xo_exp()});
        end
        wr(5'h19, 16'h8000);
        repeat (4)
        begin
            crossover_swap <= ~crossover_swap;
            // Force drop lands two edges after the write; look once settled
            idle(3);
            check({15'h0000, crossover_mode}, {15'h0000, xo_exp()});
        end
        for (int k = 0; k < 6; k++)
        begin
            step(5'h00, 1'b0, 1'b0, 16'h0000, 6'h20 >> k);
            rd(5'h10);
            rd(5'h10);
            rd(5'h10);
            rd(ofs[k]);
            rd(5'h10);
            step(ofs[k], 1'b0, 1'b1, 16'h0000, 6'h20 >> k);
            rd(5'h10);
        end
        repeat (200)
        begin
            r = $random(seed);
            step(ofs[r[2:0]], 1'b0, r[3], 16'h0000, r[9:4] & {6{r[10]}});
        end
        low_pulse(1'b1, 1'b0);
        low_pulse(1'b0, 1'b1);
        wr(5'h16, 16'h0000);
        rd(5'h16);
        low_pulse(1'b1, 1'b0);
        wr(5'h16, 16'h0100);
        do_reset();
        rd(5'h10);
        rd(5'h10);
        idle(2);
        complete_run();
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        complete_run();
    end
endmodule
